// file: common/tbsc_params.svh
// Behaviour
// - each 10-bit transmit character is captured on every reference clock rise
// - transmit bus bit zero leaves the serial output first
// - one ten-bit character serialised per reference clock period
// - wrap low sends data; wrap high holds positive high, negative low
// - wrap high feeds receiver from transmitter, low from external pair
// - each received character driven onto receive bus at either word clock rise
// - receive bus bit zero holds the earliest received bit
// - two complementary word clocks at one twentieth of the bit rate
// - align enable allows comma flag and realignment; low keeps alignment
// - comma flag high half a word clock period on 0011111 match
// - comma flag only in the complementary word clock phase
// - signal valid high for a good link, low when judged invalid
// - all-zeros character drops signal valid for the next four intervals; only one at a complementary word clock rise is checked
// - all-ones character drops signal valid for the next four intervals; only one at a complementary word clock rise is checked
// - no K28.5- within a monitoring window drops signal valid next window
// - wrap disables zeros, ones, K28.5 checks; align enable disables K28.5 only
`ifndef TBSC_PARAMS_SVH
`define TBSC_PARAMS_SVH

// register byte offsets
`define TBSC_OFF_CTRL       8'h00
`define TBSC_OFF_STATUS     8'h04
`define TBSC_OFF_IRQ_STAT   8'h08
`define TBSC_OFF_IRQ_MASK   8'h0C

// control fields
`define TBSC_CTRL_WRAP      0
`define TBSC_CTRL_ALIGN     1
`define TBSC_CTRL_RESET     2'h0

// status fields
`define TBSC_ST_VALID       0
`define TBSC_ST_HOLD        1
`define TBSC_ST_KMISS       2
`define TBSC_ST_PHASE       3

// interrupt fields
`define TBSC_IRQ_COMMA      0
`define TBSC_IRQ_LOST       1
`define TBSC_IRQ_REGAIN     2
`define TBSC_IRQ_REALIGN    3
`define TBSC_IRQ_W          4
`define TBSC_IRQ_RESET      4'h0

// character patterns, bit 0 earliest
`define TBSC_COMMA_BITS     7'h7C
`define TBSC_K285_NEG       10'h17C
`define TBSC_ALL_ZERO       10'h000
`define TBSC_ALL_ONE        10'h3FF

// timing counts
`define TBSC_CHAR_BITS      10
`define TBSC_HOLD_IVALS     3'h4
`define TBSC_K_WINDOW       65560

`endif

// file: common/tbsc_pkg.sv
package tbsc_pkg;

    // one transmission character
    typedef logic [9:0] tbsc_char_t;

    // which word clock rose for the character on the bus
    typedef enum logic
    {
        PH_TRUE = 1'b0,
        PH_COMP = 1'b1
    } tbsc_phase_e;

endpackage

// file: rtl/tbsc_ser.sv
`timescale 1ns/1ps
`include "tbsc_params.svh"

module tbsc_ser
(
    input  wire logic               clk_i,
    input  wire logic               rst_b_i,
    input  wire logic               load_i,
    input  wire tbsc_pkg::tbsc_char_t char_i,
    output wire logic               bit_o
);

    tbsc_pkg::tbsc_char_t shreg_q;

    // load on reference rise, else rotate so an idle line still toggles
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            shreg_q <= 10'h000;
        else if (load_i)
            shreg_q <= char_i;
        else
            shreg_q <= {shreg_q[0], shreg_q[9:1]};
    end

    assign bit_o = shreg_q[0];

endmodule

// file: rtl/tbsc_deser.sv
`timescale 1ns/1ps
`include "tbsc_params.svh"

module tbsc_deser
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 bit_i,
    input  wire logic                 align_en_i,
    output tbsc_pkg::tbsc_char_t      char_o,
    output logic                      strobe_o,
    output logic                      realign_o
);

    tbsc_pkg::tbsc_char_t window_q;
    tbsc_pkg::tbsc_char_t window_d;
    logic [3:0]           cnt_q;
    logic                 comma;
    logic                 emit;

    // newest bit enters at the top, earliest ends at bit zero
    assign window_d = {bit_i, window_q[9:1]};
    assign comma    = align_en_i && (window_d[6:0] == `TBSC_COMMA_BITS);
    assign emit     = (cnt_q == 4'(`TBSC_CHAR_BITS - 1)) || comma;

    // bit shifter and boundary counter
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            window_q <= 10'h000;
            cnt_q    <= 4'h0;
        end
        else
        begin
            window_q <= window_d;
            cnt_q    <= emit ? 4'h0 : cnt_q + 4'h1;
        end
    end

    // character out, realign marks a moved boundary
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            char_o    <= 10'h000;
            strobe_o  <= 1'b0;
            realign_o <= 1'b0;
        end
        else
        begin
            strobe_o  <= emit;
            realign_o <= comma && (cnt_q != 4'(`TBSC_CHAR_BITS - 1));
            if (emit)
                char_o <= window_d;
        end
    end

endmodule

// file: rtl/tbsc_top.sv
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`include "tbsc_params.svh"

module tbsc_top
#(
    parameter int K_WINDOW_CHARS = `TBSC_K_WINDOW
)
(
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_B_I,
    // apb slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic [31:0]      PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // transmit side
    input  wire logic        REFERENCE_CLOCK_I,
    input  wire logic [9:0]  TX_DATA_I,
    output logic             TX_SER_P_O,
    output logic             TX_SER_N_O,
    // receive side
    input  wire logic        RX_SER_P_I,
    input  wire logic        RX_SER_N_I,
    output logic [9:0]       RX_DATA_O,
    output logic             RX_WORD_CLOCK_O,
    output logic             RX_WORD_CLOCK_COMP_O,
    output logic             COMMA_FOUND_FLAG_O,
    output logic             SIGNAL_VALID_FLAG_O,
    // interrupt
    output logic             IRQ_O
);

    localparam int KW = 17;

    // control register
    logic [1:0]  ctrl_q;
    logic        wrap_loopback_select;
    logic        comma_align_enable;

    // reference clock and transmit bus synchronisers
    logic        ref_s1_q;
    logic        ref_s2_q;
    logic        ref_s3_q;
    logic [9:0]  tx_s1_q;
    logic [9:0]  tx_s2_q;
    logic [9:0]  tx_s3_q;
    logic        tx_load;
    logic        tx_bit;

    // receive synchronisers
    logic        rxp_s1_q;
    logic        rxp_s2_q;
    logic        rxn_s1_q;
    logic        rxn_s2_q;
    logic        rx_bit;
    logic        rx_bit_prev_q;

    // deserialiser results
    tbsc_pkg::tbsc_char_t des_char;
    logic                 des_strobe;
    logic                 des_realign;
    tbsc_pkg::tbsc_phase_e phase_q;
    tbsc_pkg::tbsc_phase_e phase_d;
    logic                 comma_char;

    // signal valid state
    logic        zeros_seen_q;
    logic        ones_seen_q;
    logic        trans_seen_q;
    logic        line_bad_q;
    logic        ival_end;
    logic        ival_fail;
    logic [2:0]  hold_q;
    logic [KW-1:0] kcnt_q;
    logic        k_seen_q;
    logic        k_miss_q;
    logic        k_check;
    logic        valid_q;
    logic        valid_prev_q;

    // interrupt state
    logic [`TBSC_IRQ_W-1:0] irq_stat_q;
    logic [`TBSC_IRQ_W-1:0] irq_mask_q;
    logic [`TBSC_IRQ_W-1:0] irq_evt;

    // apb decode
    logic        apb_setup;
    logic        apb_write;
    logic        addr_hit;

    assign wrap_loopback_select = ctrl_q[`TBSC_CTRL_WRAP];
    assign comma_align_enable   = ctrl_q[`TBSC_CTRL_ALIGN];

    // word match helper
    function automatic logic is_char(input tbsc_pkg::tbsc_char_t c, input tbsc_pkg::tbsc_char_t p);
        is_char = (c == p);
    endfunction

    // two stages plus an edge stage on the reference clock and data
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            ref_s1_q <= 1'b0;
            ref_s2_q <= 1'b0;
            ref_s3_q <= 1'b0;
            tx_s1_q  <= 10'h000;
            tx_s2_q  <= 10'h000;
            tx_s3_q  <= 10'h000;
        end
        else
        begin
            ref_s1_q <= REFERENCE_CLOCK_I;
            ref_s2_q <= ref_s1_q;
            ref_s3_q <= ref_s2_q;
            tx_s1_q  <= TX_DATA_I;
            tx_s2_q  <= tx_s1_q;
            tx_s3_q  <= tx_s2_q;
        end
    end

    // data one sample older than the clock edge is the pre-edge value
    assign tx_load = ref_s2_q && !ref_s3_q;

    tbsc_ser u_ser
    (
        .clk_i   (CLK_SYS_I),
        .rst_b_i (RST_B_I),
        .load_i  (tx_load),
        .char_i  (tx_s3_q),
        .bit_o   (tx_bit)
    );

    // serial output pair, forced during wrap
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            TX_SER_P_O <= 1'b1;
            TX_SER_N_O <= 1'b0;
        end
        else if (wrap_loopback_select)
        begin
            TX_SER_P_O <= 1'b1;
            TX_SER_N_O <= 1'b0;
        end
        else
        begin
            TX_SER_P_O <= tx_bit;
            TX_SER_N_O <= !tx_bit;
        end
    end

    // receive pair synchronisers
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            rxp_s1_q <= 1'b0;
            rxp_s2_q <= 1'b0;
            rxn_s1_q <= 1'b1;
            rxn_s2_q <= 1'b1;
        end
        else
        begin
            rxp_s1_q <= RX_SER_P_I;
            rxp_s2_q <= rxp_s1_q;
            rxn_s1_q <= RX_SER_N_I;
            rxn_s2_q <= rxn_s1_q;
        end
    end

    // receiver source: internal path under wrap, else the external pair
    assign rx_bit = wrap_loopback_select ? tx_bit : rxp_s2_q;

    tbsc_deser u_deser
    (
        .clk_i      (CLK_SYS_I),
        .rst_b_i    (RST_B_I),
        .bit_i      (rx_bit),
        .align_en_i (comma_align_enable),
        .char_o     (des_char),
        .strobe_o   (des_strobe),
        .realign_o  (des_realign)
    );

    // every character flips the phase, a realigned one too, so each gets a rising clock
    // a realigned comma may land in either phase; the flag waits for the complementary one
    // forcing a phase would emit a character with no clock edge
    always_comb
    begin
        if (phase_q == tbsc_pkg::PH_TRUE)
            phase_d = tbsc_pkg::PH_COMP;
        else
            phase_d = tbsc_pkg::PH_TRUE;
    end

    assign comma_char = (des_char[6:0] == `TBSC_COMMA_BITS);

    // receive bus, word clocks and comma flag; no signal valid term here
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            phase_q              <= tbsc_pkg::PH_COMP;
            RX_DATA_O            <= 10'h000;
            RX_WORD_CLOCK_O      <= 1'b0;
            RX_WORD_CLOCK_COMP_O <= 1'b1;
            COMMA_FOUND_FLAG_O   <= 1'b0;
        end
        else if (des_strobe)
        begin
            phase_q              <= phase_d;
            RX_DATA_O            <= des_char;
            RX_WORD_CLOCK_O      <= (phase_d == tbsc_pkg::PH_TRUE);
            RX_WORD_CLOCK_COMP_O <= (phase_d == tbsc_pkg::PH_COMP);
            COMMA_FOUND_FLAG_O   <= comma_align_enable && comma_char
                                    && (phase_d == tbsc_pkg::PH_COMP);
        end
    end

    // an interval closes at each rise of the true word clock
    assign ival_end  = des_strobe && (phase_d == tbsc_pkg::PH_TRUE);
    assign ival_fail = (!wrap_loopback_select && (zeros_seen_q || ones_seen_q))
                       || !trans_seen_q || line_bad_q;

    // per-interval observations, a hit in the closing cycle is lost
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            zeros_seen_q  <= 1'b0;
            ones_seen_q   <= 1'b0;
            trans_seen_q  <= 1'b0;
            line_bad_q    <= 1'b0;
            rx_bit_prev_q <= 1'b0;
        end
        else
        begin
            rx_bit_prev_q <= rx_bit;
            if (ival_end)
            begin
                zeros_seen_q <= 1'b0;
                ones_seen_q  <= 1'b0;
                trans_seen_q <= 1'b0;
                line_bad_q   <= 1'b0;
            end
            else
            begin
                if (des_strobe && is_char(des_char, `TBSC_ALL_ZERO))
                    zeros_seen_q <= 1'b1;
                if (des_strobe && is_char(des_char, `TBSC_ALL_ONE))
                    ones_seen_q <= 1'b1;
                if (rx_bit != rx_bit_prev_q)
                    trans_seen_q <= 1'b1;
                if (!wrap_loopback_select && (rxp_s2_q == rxn_s2_q))
                    line_bad_q <= 1'b1;
            end
        end
    end

    // four-interval hold after a failed interval
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            hold_q <= 3'h0;
        else if (ival_end && ival_fail)
            hold_q <= `TBSC_HOLD_IVALS;
        else if (ival_end && (hold_q != 3'h0))
            hold_q <= hold_q - 3'h1;
    end

    // K28.5- presence per window, only in normal mode
    assign k_check = !wrap_loopback_select && !comma_align_enable;

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            kcnt_q   <= '0;
            k_seen_q <= 1'b0;
            k_miss_q <= 1'b0;
        end
        else if (!k_check)
        begin
            kcnt_q   <= '0;
            k_seen_q <= 1'b0;
            k_miss_q <= 1'b0;
        end
        else if (des_strobe)
        begin
            if (kcnt_q == KW'(K_WINDOW_CHARS - 1))
            begin
                kcnt_q   <= '0;
                k_seen_q <= 1'b0;
                k_miss_q <= !(k_seen_q || is_char(des_char, `TBSC_K285_NEG));
            end
            else
            begin
                kcnt_q <= kcnt_q + KW'(1);
                if (is_char(des_char, `TBSC_K285_NEG))
                    k_seen_q <= 1'b1;
            end
        end
    end

    // signal valid output
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            valid_q      <= 1'b0;
            valid_prev_q <= 1'b0;
        end
        else
        begin
            valid_q      <= (hold_q == 3'h0) && !k_miss_q;
            valid_prev_q <= valid_q;
        end
    end

    assign SIGNAL_VALID_FLAG_O = valid_q;

    // interrupt events
    always_comb
    begin
        irq_evt                     = '0;
        irq_evt[`TBSC_IRQ_COMMA]    = des_strobe && comma_align_enable && comma_char
                                      && (phase_d == tbsc_pkg::PH_COMP);
        irq_evt[`TBSC_IRQ_LOST]     = valid_prev_q && !valid_q;
        irq_evt[`TBSC_IRQ_REGAIN]   = !valid_prev_q && valid_q;
        irq_evt[`TBSC_IRQ_REALIGN]  = des_realign;
    end

    // apb decode, zero wait states
    assign apb_setup = PSEL_I && !PENABLE_I;
    assign apb_write = PSEL_I && PENABLE_I && PWRITE_I;
    assign addr_hit  = (PADDR_I == `TBSC_OFF_CTRL) || (PADDR_I == `TBSC_OFF_STATUS)
                       || (PADDR_I == `TBSC_OFF_IRQ_STAT) || (PADDR_I == `TBSC_OFF_IRQ_MASK);
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_hit;

    // control and mask registers
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            ctrl_q     <= `TBSC_CTRL_RESET;
            irq_mask_q <= `TBSC_IRQ_RESET;
        end
        else if (apb_write)
        begin
            if (PADDR_I == `TBSC_OFF_CTRL)
                ctrl_q <= PWDATA_I[1:0];
            if (PADDR_I == `TBSC_OFF_IRQ_MASK)
                irq_mask_q <= PWDATA_I[`TBSC_IRQ_W-1:0];
        end
    end

    // sticky status, write one clears, a new event wins
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            irq_stat_q <= `TBSC_IRQ_RESET;
        else if (apb_write && (PADDR_I == `TBSC_OFF_IRQ_STAT))
            irq_stat_q <= (irq_stat_q & ~PWDATA_I[`TBSC_IRQ_W-1:0]) | irq_evt;
        else
            irq_stat_q <= irq_stat_q | irq_evt;
    end

    // read data captured in the setup cycle
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            PRDATA_O <= 32'h0000_0000;
        else if (apb_setup)
        begin
            unique case (PADDR_I)
                `TBSC_OFF_CTRL:     PRDATA_O <= {30'h0, ctrl_q};
                `TBSC_OFF_STATUS:   PRDATA_O <= {28'h0, phase_q == tbsc_pkg::PH_COMP,
                                                 k_miss_q, hold_q != 3'h0, valid_q};
                `TBSC_OFF_IRQ_STAT: PRDATA_O <= {28'h0, irq_stat_q};
                `TBSC_OFF_IRQ_MASK: PRDATA_O <= {28'h0, irq_mask_q};
                default:            PRDATA_O <= 32'h0000_0000;
            endcase
        end
    end

    // level interrupt
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            IRQ_O <= 1'b0;
        else
            IRQ_O <= |(irq_stat_q & irq_mask_q);
    end

endmodule

// file: tb/tbsc_monitor.sv
`timescale 1ns/1ps

module tbsc_monitor
#(
    parameter int K_WINDOW_CHARS = 65560
)
(
    input wire logic       CLK_SYS_I,
    input wire logic       RST_B_I,
    input wire logic       PSEL_I,
    input wire logic       PENABLE_I,
    input wire logic       PREADY_O,
    input wire logic       PSLVERR_O,
    input wire logic       TX_SER_P_O,
    input wire logic       TX_SER_N_O,
    input wire logic [9:0] RX_DATA_O,
    input wire logic       RX_WORD_CLOCK_O,
    input wire logic       RX_WORD_CLOCK_COMP_O,
    input wire logic       COMMA_FOUND_FLAG_O,
    input wire logic       SIGNAL_VALID_FLAG_O
);
    // one clock domain, checks paused in reset
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RST_B_I);

    // flag stays up for ten system cycles
    sequence s_flag_run;
        COMMA_FOUND_FLAG_O [*8] ##1 COMMA_FOUND_FLAG_O ##1 COMMA_FOUND_FLAG_O;
    endsequence
    // next character boundary within one character time
    sequence s_next_char;
        ##[1:10] $changed(RX_WORD_CLOCK_O);
    endsequence

    property p_tx_pair;
        TX_SER_N_O != TX_SER_P_O;
    endproperty
    property p_wclk_comp;
        RX_WORD_CLOCK_COMP_O == !RX_WORD_CLOCK_O;
    endproperty
    property p_comma_phase;
        COMMA_FOUND_FLAG_O |-> RX_WORD_CLOCK_COMP_O;
    endproperty
    property p_comma_len;
        $rose(COMMA_FOUND_FLAG_O) |-> s_flag_run ##1 !COMMA_FOUND_FLAG_O;
    endproperty
    property p_data_clk;
        $changed(RX_DATA_O) |-> $changed(RX_WORD_CLOCK_O);
    endproperty
    property p_wclk_gap;
        $changed(RX_WORD_CLOCK_O) |-> s_next_char;
    endproperty
    property p_valid_hold;
        $fell(SIGNAL_VALID_FLAG_O) |-> !SIGNAL_VALID_FLAG_O [*8];
    endproperty
    property p_slverr;
        PSLVERR_O |-> PSEL_I && PENABLE_I;
    endproperty
    property p_ready;
        PREADY_O;
    endproperty

    a_tx_pair: assert property (p_tx_pair) else $error("serial pair not complementary");
    a_wclk_comp: assert property (p_wclk_comp) else $error("word clocks not complementary");
    a_comma_phase: assert property (p_comma_phase) else $error("comma flag in true phase");
    a_comma_len: assert property (p_comma_len) else $error("comma flag width wrong");
    a_data_clk: assert property (p_data_clk) else $error("receive bus moved without clock");
    a_wclk_gap: assert property (p_wclk_gap) else $error("word clock stalled");
    a_valid_hold: assert property (p_valid_hold) else $error("valid flag low too briefly");
    a_slverr: assert property (p_slverr) else $error("error outside access phase");
    a_ready: assert property (p_ready) else $error("ready low");
endmodule

// file: tb/tbsc_ctrl_model.sv
`timescale 1ns/1ps

module tbsc_ctrl_model
(
    input  wire logic       run_i,
    input  wire logic [9:0] char_i,
    output logic            ref_clk_o,
    output logic [9:0]      tx_data_o
);
    // reference clock, ten system cycles a period, still when idle
    initial ref_clk_o = 1'b0;
    always #100 ref_clk_o = run_i ? ~ref_clk_o : 1'b0;

    // character changes mid-period, far from the capturing rise
    initial tx_data_o = 10'h000;
    always @(negedge ref_clk_o)
    begin
        tx_data_o <= run_i ? char_i : ~tx_data_o;
    end
endmodule

// file: tb/tbsc_bench.sv
`timescale 1ns/1ps
`include "tbsc_params.svh"

module tbsc_bench;
    localparam int         KWIN   = 40;
    localparam logic [7:0] A_CTRL = `TBSC_OFF_CTRL;
    localparam logic [7:0] A_STAT = `TBSC_OFF_IRQ_STAT;
    localparam logic [7:0] A_MASK = `TBSC_OFF_IRQ_MASK;
    localparam logic [9:0] K_CH   = `TBSC_K285_NEG;

    logic        clk       = 1'b0;
    logic        rst_b     = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0;
    logic        rx_p      = 1'b0;
    logic        run       = 1'b1;
    logic [9:0]  send_char = `TBSC_K285_NEG;
    logic [31:0] prdata, q;
    logic        pready, pslverr, e, ref_clk, tx_p, tx_n, wclk, wclk_c, comma, valid, irq;
    logic [9:0]  tx_data, rx_data;
    int          bad_count = 0;
    int          n_compared = 0;
    int          hits;
    logic [9:0]  hits_tbl [2] = '{`TBSC_ALL_ZERO, `TBSC_ALL_ONE};

    always #10 clk = ~clk;

    // external line fed from own serial output
    always @(posedge clk)
    begin
        rx_p <= tx_p;
    end

    tbsc_ctrl_model ctrl_u (.run_i(run), .char_i(send_char), .ref_clk_o(ref_clk), .tx_data_o(tx_data));

    tbsc_top #(.K_WINDOW_CHARS(KWIN)) dut_u (.CLK_SYS_I(clk), .RST_B_I(rst_b), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .REFERENCE_CLOCK_I(ref_clk), .TX_DATA_I(tx_data),
        .TX_SER_P_O(tx_p), .TX_SER_N_O(tx_n), .RX_SER_P_I(rx_p), .RX_SER_N_I(~rx_p), .RX_DATA_O(rx_data),
        .RX_WORD_CLOCK_O(wclk), .RX_WORD_CLOCK_COMP_O(wclk_c), .COMMA_FOUND_FLAG_O(comma),
        .SIGNAL_VALID_FLAG_O(valid), .IRQ_O(irq));

    // verdict and end of run
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer: setup, then access until ready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            check("apb ready", 32'(pready), 32'h1);
            wrap_up();
        end
    endtask

    // bounded wait for comma flag (0) or valid flag (1) to reach a level
    task automatic wait_for(input int which, input logic lvl, input int lim);
        int n;
        n = 0;
        while ((which == 0 ? comma : valid) !== lvl && n < lim)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= lim)
        begin
            check("flag wait", 32'(which == 0 ? comma : valid), 32'(lvl));
            wrap_up();
        end
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        apb(0, A_CTRL, 0);
        check("ctrl reset", q, 32'h0);
        apb(0, A_MASK, 0);
        check("mask reset", q, 32'h0);
        apb(0, 8'h10, 0);
        check("unmapped data", q, 32'h0);
        check("unmapped err", 32'(e), 32'h1);
        apb(1, A_CTRL, 32'h3);
        apb(0, A_CTRL, 0);
        check("ctrl rw", q, 32'h3);
        $display("test registers done");

        // wrap with alignment: internal path, comma aligned
        repeat (4) @(posedge clk);
        #1;
        check("tx pos wrap", 32'(tx_p), 32'h1);
        check("tx neg wrap", 32'(tx_n), 32'h0);
        wait_for(0, 1'b1, 600);
        check("rx char", 32'(rx_data), 32'(K_CH));
        check("comma phase", 32'(wclk_c), 32'h1);
        apb(0, A_STAT, 0);
        check("comma event", q & 32'h1, 32'h1);
        check("irq masked", 32'(irq), 32'h0);
        apb(1, A_MASK, 32'h1);
        repeat (3) @(posedge clk);
        #1;
        check("irq raised", 32'(irq), 32'h1);
        $display("test loopback done");

        // alignment off: no comma flag, alignment kept
        apb(1, A_CTRL, 32'h1);
        repeat (30) @(posedge clk);
        apb(1, A_STAT, 32'h1);
        hits = 0;
        repeat (100)
        begin
            @(posedge clk);
            #1;
            hits += int'(comma === 1'b1);
        end
        check("comma count", 32'(hits), 32'h0);
        check("rx kept", 32'(rx_data), 32'(K_CH));
        apb(0, A_STAT, 0);
        check("comma cleared", q & 32'h1, 32'h0);
        check("irq cleared", 32'(irq), 32'h0);
        $display("test align off done");

        // external line: bit order and one character a period
        apb(1, A_CTRL, 32'h2);
        wait_for(0, 1'b1, 600);
        // the first flag may come from the splice of old and new line
        wait_for(0, 1'b0, 30);
        wait_for(0, 1'b1, 600);
        check("ext char", 32'(rx_data), 32'(K_CH));
        wait_for(1, 1'b1, 1500);
        check("valid up", 32'(valid), 32'h1);
        foreach (hits_tbl[i])
        begin
            send_char <= hits_tbl[i];
            wait_for(1, 1'b0, 300);
            check("valid bad char", 32'(valid), 32'h0);
            send_char <= K_CH;
            wait_for(1, 1'b1, 1500);
            check("valid back", 32'(valid), 32'h1);
        end
        $display("test signal valid done");

        // missing K28.5 in normal mode, ignored with align enable
        apb(1, A_CTRL, 32'h0);
        send_char <= 10'h2AA;
        wait_for(1, 1'b0, 1500);
        check("valid no k", 32'(valid), 32'h0);
        send_char <= K_CH;
        wait_for(1, 1'b1, 2000);
        apb(1, A_CTRL, 32'h2);
        send_char <= 10'h2AA;
        repeat (1200) @(posedge clk);
        #1;
        check("valid k ignored", 32'(valid), 32'h1);
        $display("test k window done");
        wrap_up();
    end

    // cut a hang short
    initial
    begin
        #1900000;
        check("run time", 32'h1, 32'h0);
        wrap_up();
    end
endmodule

bind tbsc_top tbsc_monitor #(.K_WINDOW_CHARS(K_WINDOW_CHARS)) mon_u (.CLK_SYS_I(CLK_SYS_I),
    .RST_B_I(RST_B_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .TX_SER_P_O(TX_SER_P_O), .TX_SER_N_O(TX_SER_N_O), .RX_DATA_O(RX_DATA_O), .RX_WORD_CLOCK_O(RX_WORD_CLOCK_O),
    .RX_WORD_CLOCK_COMP_O(RX_WORD_CLOCK_COMP_O), .COMMA_FOUND_FLAG_O(COMMA_FOUND_FLAG_O),
    .SIGNAL_VALID_FLAG_O(SIGNAL_VALID_FLAG_O));
